/* File: shared/gdreg_pkg.sv */
package gdreg_pkg;
   // Register map, 4-bit word addresses
   localparam logic [3:0] ADDR_FAULT_PRIMARY = 4'h0;
   localparam logic [3:0] ADDR_FAULT_SECONDARY = 4'h1;
   localparam logic [3:0] ADDR_DRIVER_SETTINGS = 4'h2;
   localparam logic [3:0] ADDR_LOCK_CTRL = 4'h3;
   localparam int DATA_W = 11;
   localparam int ADDR_W = 4;
   localparam int FRAME_BITS = 16;
   localparam int HEADER_BITS = 5;
   localparam logic [10:0] STATUS_RESET = 11'h000;
   localparam logic [10:0] SETTINGS_RESET = 11'h000;

   // Primary status fields
   localparam int P_SUMMARY = 10;
   localparam int P_DS_OC = 9;
   localparam int P_GATE_ERR = 8;
   localparam int P_SUPPLY_UNDERVOLTAGE_LOCKOUT = 7;
   localparam int P_OVERTEMP_SHUTDOWN = 6;

   // Secondary status fields
   localparam int S_AMP_A = 10;
   localparam int S_AMP_C = 8;
   localparam int S_WARN = 7;
   localparam int S_GATE_SUPPLY_UNDERVOLTAGE = 6;

   // Driver settings fields
   localparam int C_SCOPE_ALL = 10;
   localparam int C_GATE_SUPPLY_UNDERVOLTAGE_DIS = 9;
   localparam int C_GDF_DIS = 8;
   localparam int C_WARN_REP = 7;
   localparam int C_MODE_HI = 6;
   localparam int C_MODE_LO = 5;
   localparam int C_ASYNC = 4;
   localparam int C_DIR = 3;
   localparam int C_COAST = 2;
   localparam int C_BRAKE = 1;
   localparam int C_CLEAR = 0;

   // Lock field sits in bits 10:8 of the lock register
   localparam int L_HI = 10;
   localparam int L_LO = 8;
   localparam logic [2:0] LOCK_PATTERN = 3'h6;
   localparam logic [2:0] UNLOCK_PATTERN = 3'h3;

   typedef enum logic [1:0]
   {
      GDREG_MODE_SIX,
      GDREG_MODE_THREE,
      GDREG_MODE_SINGLE,
      GDREG_MODE_INDEP
   } gdreg_mode_t;
endpackage

/* File: core/gdreg_spi.sv */
`timescale 1ns/1ps
// Serial slave: 16-bit frame, bit 15 read flag, 14:11 address, 10:0 data.
// Sampled on the falling serial edge, shifted out on the rising edge.
module gdreg_spi
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic mosi,
   input wire logic [10:0] rd_data,
   output logic [3:0] addr_r,
   output logic wr_pulse_r,
   output logic [10:0] wr_data_r,
   output logic miso_r,
   output logic miso_oe_r
);
   logic sclk_d_r;
   logic [15:0] rx_r;
   logic [4:0] cnt_r;
   logic [10:0] tx_r;
   logic fall;
   logic rise;

   assign fall = sclk_d_r && !sclk && !cs_n;
   assign rise = !sclk_d_r && sclk && !cs_n;

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         sclk_d_r <= 1'b0;
      else
         sclk_d_r <= sclk;
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rx_r <= 16'h0000;
         cnt_r <= 5'h00;
         addr_r <= 4'h0;
      end
      else if (cs_n)
         cnt_r <= 5'h00;
      else if (fall)
      begin
         rx_r <= {rx_r[14:0], mosi};
         cnt_r <= cnt_r + 5'h01;
         if (cnt_r == 5'(gdreg_pkg::HEADER_BITS - 1))
            addr_r <= {rx_r[2:0], mosi};
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_pulse_r <= 1'b0;
         wr_data_r <= 11'h000;
      end
      else
      begin
         wr_pulse_r <= fall && !rx_r[14]
            && cnt_r == 5'(gdreg_pkg::FRAME_BITS - 1);
         if (fall)
            wr_data_r <= {rx_r[9:0], mosi};
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tx_r <= 11'h000;
         miso_r <= 1'b0;
         miso_oe_r <= 1'b0;
      end
      else
      begin
         miso_oe_r <= !cs_n;
         if (cs_n)
            miso_r <= 1'b0;
         else if (rise && cnt_r == 5'(gdreg_pkg::HEADER_BITS))
         begin
            miso_r <= rd_data[10];
            tx_r <= {rd_data[9:0], 1'b0};
         end
         else if (rise && cnt_r > 5'(gdreg_pkg::HEADER_BITS))
         begin
            miso_r <= tx_r[10];
            tx_r <= {tx_r[9:0], 1'b0};
         end
      end
   end
endmodule

/* File: core/gdreg_bank.sv */
`timescale 1ns/1ps
module gdreg_bank
#(
   parameter bit HAS_AMP = 1'b1
)
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic mosi,
   input wire logic [5:0] ds_oc_in,
   input wire logic [5:0] gate_err_in,
   input wire logic supply_undervoltage_lockout_in,
   input wire logic overtemp_shutdown_in,
   input wire logic warn_in,
   input wire logic gate_supply_undervoltage_in,
   input wire logic [2:0] amp_oc_in,
   input wire logic dir_pin,
   input wire logic brake_pin,
   output logic miso,
   output logic miso_oe,
   output logic error_pin_n,
   output logic [2:0] half_bridge_off,
   output logic coast_all,
   output logic brake_all,
   output logic [1:0] pwm_mode,
   output logic async_rect,
   output logic direction_eff
);
   logic [9:0] prim_r;
   logic [10:0] sec_r;
   logic [10:0] ctrl_r;
   logic [2:0] lock_r;
   logic summary_r;
   logic error_pin_n_r;
   logic [2:0] hb_off_r;
   logic coast_r;
   logic brake_r;
   logic [1:0] mode_r;
   logic async_r;
   logic dir_r;
   logic [3:0] addr;
   logic wr_pulse;
   logic [10:0] wr_data;
   logic [10:0] rd_data;
   logic [9:0] prim_nxt;
   logic [10:0] sec_nxt;
   logic summary_nxt;
   logic clear_cmd;
   logic locked;
   logic wr_ctrl;
   logic wr_lock;
   logic single_mode;
   logic [5:0] gate_set;
   logic [2:0] amp_set;
   logic [2:0] phase_oc;

   gdreg_spi u_spi
   (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .sclk(sclk),
      .cs_n(cs_n),
      .mosi(mosi),
      .rd_data(rd_data),
      .addr_r(addr),
      .wr_pulse_r(wr_pulse),
      .wr_data_r(wr_data),
      .miso_r(miso),
      .miso_oe_r(miso_oe)
   );

   assign clear_cmd = ctrl_r[gdreg_pkg::C_CLEAR];
   assign locked = lock_r == gdreg_pkg::LOCK_PATTERN;
   assign wr_ctrl = wr_pulse && addr == gdreg_pkg::ADDR_DRIVER_SETTINGS;
   assign wr_lock = wr_pulse && addr == gdreg_pkg::ADDR_LOCK_CTRL;
   assign single_mode = gdreg_pkg::gdreg_mode_t'(
      ctrl_r[gdreg_pkg::C_MODE_HI:gdreg_pkg::C_MODE_LO])
      == gdreg_pkg::GDREG_MODE_SINGLE;

   assign gate_set = gate_err_in & {6{!ctrl_r[gdreg_pkg::C_GDF_DIS]}};
   assign amp_set = HAS_AMP ? amp_oc_in : 3'h0;

   always_comb
   begin
      prim_nxt = clear_cmd ? 10'h000 : prim_r;
      sec_nxt = clear_cmd ? 11'h000 : sec_r;
      prim_nxt[5:0] = prim_nxt[5:0] | ds_oc_in;
      prim_nxt[gdreg_pkg::P_DS_OC] = prim_nxt[gdreg_pkg::P_DS_OC]
         | (|ds_oc_in);
      prim_nxt[gdreg_pkg::P_GATE_ERR] = prim_nxt[gdreg_pkg::P_GATE_ERR]
         | (|gate_set);
      prim_nxt[gdreg_pkg::P_SUPPLY_UNDERVOLTAGE_LOCKOUT] = prim_nxt[gdreg_pkg::P_SUPPLY_UNDERVOLTAGE_LOCKOUT] | supply_undervoltage_lockout_in;
      prim_nxt[gdreg_pkg::P_OVERTEMP_SHUTDOWN] = prim_nxt[gdreg_pkg::P_OVERTEMP_SHUTDOWN] | overtemp_shutdown_in;
      sec_nxt[gdreg_pkg::S_AMP_A:gdreg_pkg::S_AMP_C] =
         sec_nxt[gdreg_pkg::S_AMP_A:gdreg_pkg::S_AMP_C] | amp_set;
      sec_nxt[gdreg_pkg::S_WARN] = sec_nxt[gdreg_pkg::S_WARN] | warn_in;
      sec_nxt[gdreg_pkg::S_GATE_SUPPLY_UNDERVOLTAGE] = sec_nxt[gdreg_pkg::S_GATE_SUPPLY_UNDERVOLTAGE]
         | (gate_supply_undervoltage_in & !ctrl_r[gdreg_pkg::C_GATE_SUPPLY_UNDERVOLTAGE_DIS]);
      sec_nxt[5:0] = sec_nxt[5:0] | gate_set;
      summary_nxt = (|prim_nxt) | (|sec_nxt[10:8]) | (|sec_nxt[6:0])
         | (sec_nxt[gdreg_pkg::S_WARN] & ctrl_r[gdreg_pkg::C_WARN_REP]);
   end

   // status reset and no write path
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         prim_r <= gdreg_pkg::STATUS_RESET[9:0];
         sec_r <= gdreg_pkg::STATUS_RESET;
      end
      else
      begin
         prim_r <= prim_nxt;
         sec_r <= sec_nxt;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         summary_r <= 1'b0;
         error_pin_n_r <= 1'b1;
      end
      else
      begin
         summary_r <= summary_nxt;
         error_pin_n_r <= !summary_nxt;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         ctrl_r <= gdreg_pkg::SETTINGS_RESET;
      else if (wr_ctrl && locked)
         ctrl_r <= {ctrl_r[10:3], wr_data[2:0]};
      else if (wr_ctrl)
         ctrl_r <= wr_data;
      else
         ctrl_r[gdreg_pkg::C_CLEAR] <= 1'b0;
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         lock_r <= gdreg_pkg::UNLOCK_PATTERN;
      else if (wr_lock && !locked
         && wr_data[gdreg_pkg::L_HI:gdreg_pkg::L_LO]
         == gdreg_pkg::LOCK_PATTERN)
         lock_r <= gdreg_pkg::LOCK_PATTERN;
      else if (wr_lock && locked
         && wr_data[gdreg_pkg::L_HI:gdreg_pkg::L_LO]
         == gdreg_pkg::UNLOCK_PATTERN)
         lock_r <= gdreg_pkg::UNLOCK_PATTERN;
   end

   always_comb
   begin
      rd_data = 11'h000;
      case (addr)
         gdreg_pkg::ADDR_FAULT_PRIMARY:
            rd_data = {summary_r, prim_r};
         gdreg_pkg::ADDR_FAULT_SECONDARY:
            rd_data = sec_r;
         gdreg_pkg::ADDR_DRIVER_SETTINGS:
            rd_data = ctrl_r;
         gdreg_pkg::ADDR_LOCK_CTRL:
            rd_data[gdreg_pkg::L_HI:gdreg_pkg::L_LO] = lock_r;
         default:
            rd_data = 11'h000;
      endcase
   end

   // Per-phase overcurrent: both transistors plus amplifier
   genvar p;
   generate
      for (p = 0; p < 3; p++)
      begin : g_phase
         assign phase_oc[p] = prim_r[5 - 2 * p] | prim_r[4 - 2 * p]
            | sec_r[gdreg_pkg::S_AMP_A - p];
         always_ff @(posedge ref_clk or negedge rst_n)
         begin
            if (!rst_n)
               hb_off_r[p] <= 1'b0;
            else if (ctrl_r[gdreg_pkg::C_SCOPE_ALL])
               hb_off_r[p] <= |phase_oc;
            else
               hb_off_r[p] <= phase_oc[p];
         end
      end
   endgenerate

   // Drive controls
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         coast_r <= 1'b0;
         brake_r <= 1'b0;
         mode_r <= 2'h0;
         async_r <= 1'b0;
         dir_r <= 1'b0;
      end
      else
      begin
         coast_r <= ctrl_r[gdreg_pkg::C_COAST];
         brake_r <= ctrl_r[gdreg_pkg::C_BRAKE] | (single_mode & brake_pin);
         mode_r <= ctrl_r[gdreg_pkg::C_MODE_HI:gdreg_pkg::C_MODE_LO];
         async_r <= single_mode & ctrl_r[gdreg_pkg::C_ASYNC];
         dir_r <= single_mode & (ctrl_r[gdreg_pkg::C_DIR] | dir_pin);
      end
   end

   assign error_pin_n = error_pin_n_r;
   assign half_bridge_off = hb_off_r;
   assign coast_all = coast_r;
   assign brake_all = brake_r;
   assign pwm_mode = mode_r;
   assign async_rect = async_r;
   assign direction_eff = dir_r;

   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);

   pin_mirror_a: assert property (error_pin_n_r == !summary_r)
      else $error("error pin disagrees with summary bit");

   ds_aggregate_a: assert property (
      (ds_oc_in != 6'h00) |=> prim_r[gdreg_pkg::P_DS_OC])
      else $error("drain overcurrent aggregate not set");

   ds_phase_a_a: assert property (ds_oc_in[5] |=> prim_r[5])
      else $error("phase A high drain bit not set");

   amp_latch_a: assert property (
      (HAS_AMP && amp_oc_in[0]) |=> sec_r[gdreg_pkg::S_AMP_A])
      else $error("amplifier A overcurrent not latched");

   gate_supply_undervoltage_mask_a: assert property (
      (ctrl_r[gdreg_pkg::C_GATE_SUPPLY_UNDERVOLTAGE_DIS] && !sec_r[gdreg_pkg::S_GATE_SUPPLY_UNDERVOLTAGE])
      |=> !sec_r[gdreg_pkg::S_GATE_SUPPLY_UNDERVOLTAGE])
      else $error("supply fault latched while disabled");

   gdf_mask_a: assert property (
      (ctrl_r[gdreg_pkg::C_GDF_DIS] && sec_r[5:0] == 6'h00)
      |=> sec_r[5:0] == 6'h00)
      else $error("gate fault latched while disabled");

   warn_report_a: assert property (
      (ctrl_r[gdreg_pkg::C_WARN_REP] && sec_r[gdreg_pkg::S_WARN]
      && !clear_cmd) |=> (summary_r && !error_pin_n_r))
      else $error("reported warning missing from pin");

   scope_all_a: assert property (
      (ctrl_r[gdreg_pkg::C_SCOPE_ALL] && prim_r[5:0] != 6'h00)
      |=> hb_off_r == 3'h7)
      else $error("scope all did not stop every half-bridge");

   clear_self_a: assert property (
      (clear_cmd && !wr_ctrl) |=> !clear_cmd)
      else $error("clear command did not return to zero");

   clear_wipe_a: assert property (
      (clear_cmd && ds_oc_in == 6'h00) |=> prim_r[5:0] == 6'h00)
      else $error("clear did not wipe drain fault bits");

   latch_hold_a: assert property (
      (prim_r[5] && !clear_cmd) |=> prim_r[5])
      else $error("latched fault dropped without clear");

   lock_hold_a: assert property (
      (locked && wr_ctrl) |=> $stable(ctrl_r[10:3]))
      else $error("locked settings changed by write");

   coast_follow_a: assert property (
      $rose(ctrl_r[gdreg_pkg::C_COAST]) |=> coast_r)
      else $error("coast command not applied");

   settings_write_a: assert property (
      (wr_ctrl && !locked) |=> ctrl_r == $past(wr_data))
      else $error("settings write did not land");

   brake_follow_a: assert property (
      ctrl_r[gdreg_pkg::C_BRAKE] |=> brake_r)
      else $error("brake command not applied");

   mode_follow_a: assert property (
      $changed(ctrl_r[gdreg_pkg::C_MODE_HI:gdreg_pkg::C_MODE_LO]) |=>
      mode_r == $past(ctrl_r[gdreg_pkg::C_MODE_HI:gdreg_pkg::C_MODE_LO]))
      else $error("input mode output does not follow settings");

   dir_gate_a: assert property (
      !single_mode |=> !dir_r)
      else $error("direction active outside single-input mode");

   unlisted_ignore_a: assert property (
      (wr_pulse && addr > gdreg_pkg::ADDR_LOCK_CTRL)
      |=> ($stable(ctrl_r[10:1]) && $stable(lock_r)))
      else $error("write to unlisted address changed a register");

   gate_phase_a_a: assert property (
      (gate_err_in[5] && !ctrl_r[gdreg_pkg::C_GDF_DIS]) |=> sec_r[5])
      else $error("phase A high gate fault not latched");

   warn_latch_a: assert property (
      warn_in |=> sec_r[gdreg_pkg::S_WARN])
      else $error("temperature warning not latched");
endmodule

/* File: dv/gdreg_host.sv */
`timescale 1ns/1ps
module gdreg_host
(
   input wire logic ref_clk,
   input wire logic miso,
   output logic sclk,
   output logic cs_n,
   output logic mosi
);
   initial
   begin
      sclk = 1'b0;
      cs_n = 1'b1;
      mosi = 1'b0;
   end

   // Slow serial clock: four ref_clk cycles high, five ref_clk cycles low
   task automatic xfer(input logic [15:0] frame, output logic [10:0] q);
      q = 11'h000;
      @(posedge ref_clk);
      cs_n <= 1'b0;
      for (int i = 15; i >= 0; i--)
      begin
         @(posedge ref_clk);
         mosi <= frame[i];
         sclk <= 1'b1;
         repeat (4) @(posedge ref_clk);
         if (i <= 10)
            q[i] = miso;
         sclk <= 1'b0;
         repeat (4) @(posedge ref_clk);
      end
      cs_n <= 1'b1;
      // Released line shows no stale bit
      mosi <= ~frame[0];
      repeat (4) @(posedge ref_clk);
   endtask
endmodule

/* File: dv/gdreg_bank_tb.sv */
`timescale 1ns/1ps
module gdreg_bank_tb;
   logic ref_clk;
   logic rst_n;
   logic sclk;
   logic cs_n;
   logic mosi;
   logic miso;
   logic [18:0] ev_v;
   logic dir_pin;
   logic brake_pin;
   logic error_pin_n;
   logic [2:0] half_bridge_off;
   logic coast_all;
   logic brake_all;
   logic [1:0] pwm_mode;
   logic async_rect;
   logic direction_eff;
   int errors;
   int check_count;

   gdreg_bank dut_u
   (
      .ref_clk(ref_clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n),
      .mosi(mosi), .ds_oc_in(ev_v[18:13]), .gate_err_in(ev_v[12:7]),
      .supply_undervoltage_lockout_in(ev_v[6]), .overtemp_shutdown_in(ev_v[5]), .warn_in(ev_v[4]),
      .gate_supply_undervoltage_in(ev_v[3]), .amp_oc_in(ev_v[2:0]), .dir_pin(dir_pin),
      .brake_pin(brake_pin), .miso(miso), .miso_oe(),
      .error_pin_n(error_pin_n), .half_bridge_off(half_bridge_off),
      .coast_all(coast_all), .brake_all(brake_all), .pwm_mode(pwm_mode),
      .async_rect(async_rect), .direction_eff(direction_eff)
   );

   gdreg_host host_u
   (
      .ref_clk(ref_clk), .miso(miso), .sclk(sclk), .cs_n(cs_n),
      .mosi(mosi)
   );

   task automatic chk(input string what, input logic [10:0] exp,
                      input logic [10:0] got);
      check_count++;
      if (got !== exp)
      begin
         errors++;
         $display("BAD %s exp %h got %h", what, exp, got);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [10:0] d);
      logic [10:0] q;
      host_u.xfer({1'b0, a, d}, q);
   endtask

   task automatic rd(input logic [3:0] a, input logic [10:0] exp);
      logic [10:0] q;
      host_u.xfer({1'b1, a, 11'h000}, q);
      chk($sformatf("reg %h", a), exp, q);
   endtask

   task automatic pins(input logic e, input logic [2:0] h,
                       input logic [1:0] cb, input logic [1:0] m,
                       input logic [1:0] ad);
      chk("pins", {1'b0, e, h, cb, m, ad}, {1'b0, error_pin_n,
          half_bridge_off, coast_all, brake_all, pwm_mode, async_rect,
          direction_eff});
   endtask

   task automatic pulse(input logic [18:0] v);
      @(posedge ref_clk);
      ev_v <= v;
      @(posedge ref_clk);
      ev_v <= 19'h00000;
      repeat (3) @(posedge ref_clk);
   endtask

   task automatic t_reset();
      pins(1'b1, 3'h0, 2'h0, 2'h0, 2'h0);
      rd(4'h0, 11'h000);
      rd(4'h1, 11'h000);
      rd(4'h2, 11'h000);
      $display("test reset done");
   endtask

   task automatic t_modes();
      logic [10:0] v;
      logic s;
      @(posedge ref_clk);
      brake_pin <= 1'b1;
      for (int m = 0; m < 4; m++)
      begin
         v = {4'h0, m[1:0], 5'h18};
         s = (m == 2);
         wr(4'h2, v);
         rd(4'h2, v);
         pins(1'b1, 3'h0, {1'b0, s}, m[1:0], {s, s});
      end
      dir_pin <= 1'b1;
      wr(4'h2, 11'h040);
      pins(1'b1, 3'h0, 2'h1, 2'h2, 2'h1);
      wr(4'h2, 11'h006);
      pins(1'b1, 3'h0, 2'h3, 2'h0, 2'h0);
      dir_pin <= 1'b0;
      brake_pin <= 1'b0;
      wr(4'h2, 11'h000);
      $display("test modes done");
   endtask

   task automatic t_latch();
      for (int i = 0; i < 6; i++)
      begin
         pulse(19'(1) << (13 + i));
         wr(4'h0, 11'h000);
         rd(4'h0, 11'h600 | (11'h1 << i));
         pins(1'b0, 3'(1 << ((5 - i) / 2)), 2'h0, 2'h0, 2'h0);
         wr(4'h2, 11'h001);
         rd(4'h0, 11'h000);
      end
      rd(4'h2, 11'h000);
      wr(4'h2, 11'h400);
      pulse(19'h02000);
      pins(1'b0, 3'h7, 2'h0, 2'h0, 2'h0);
      wr(4'h2, 11'h001);
      $display("test latch done");
   endtask

   task automatic t_faults();
      pulse({6'h00, 6'h21, 4'hd, 3'h0});
      rd(4'h0, 11'h5c0);
      rd(4'h1, 11'h061);
      wr(4'h2, 11'h001);
      pulse({16'h0000, 3'h5});
      rd(4'h1, 11'h500);
      pins(1'b0, 3'h5, 2'h0, 2'h0, 2'h0);
      wr(4'h2, 11'h001);
      pulse({14'h0000, 1'b1, 4'h0});
      rd(4'h1, 11'h080);
      pins(1'b1, 3'h0, 2'h0, 2'h0, 2'h0);
      wr(4'h2, 11'h080);
      pins(1'b0, 3'h0, 2'h0, 2'h0, 2'h0);
      rd(4'h0, 11'h400);
      wr(4'h2, 11'h301);
      pulse({6'h00, 6'h3f, 4'h1, 3'h0});
      rd(4'h1, 11'h000);
      rd(4'h0, 11'h000);
      wr(4'h2, 11'h000);
      $display("test faults done");
   endtask

   task automatic t_lock();
      wr(4'h3, 11'h600);
      wr(4'h2, 11'h01c);
      rd(4'h2, 11'h004);
      pins(1'b1, 3'h0, 2'h2, 2'h0, 2'h0);
      wr(4'h3, 11'h500);
      wr(4'h2, 11'h018);
      rd(4'h2, 11'h000);
      wr(4'h3, 11'h300);
      wr(4'h2, 11'h018);
      rd(4'h2, 11'h018);
      wr(4'h9, 11'h7ff);
      rd(4'h9, 11'h000);
      rd(4'h2, 11'h018);
      wr(4'h2, 11'h000);
      $display("test lock done");
   endtask

   task automatic summarize();
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   initial
   begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   initial
   begin
      repeat (60000) @(posedge ref_clk);
      errors++;
      $display("BAD watchdog exp done got hang");
      summarize();
   end

   initial
   begin
      errors = 0;
      check_count = 0;
      rst_n = 1'b0;
      ev_v = 19'h00000;
      dir_pin = 1'b0;
      brake_pin = 1'b0;
      repeat (5) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge ref_clk);
      t_reset();
      t_modes();
      t_latch();
      t_faults();
      t_lock();
      summarize();
   end
endmodule
